/* common/tpc_pkg.sv */
// tpc_pkg: constants, types and register layout for the per-port tdm ingress config register
// assumes: one port instance, 16-bit microprocessor port with word addresses as printed
package tpc_pkg;
    localparam logic [15:0] REG_BASE        = 16'h6200;
    localparam logic [15:0] PORT_STRIDE     = 16'h0010;
    localparam logic [15:0] CFG_RESET       = 16'h0000;
    localparam logic [15:0] LOWER_MASK      = 16'h007f; // lower bits live elsewhere
    localparam int          POS_SAMPLE_EDGE = 7;
    localparam int          POS_CLK_RATE    = 8;
    localparam int          POS_LINK_TYPE   = 9;
    localparam int          POS_LOSS_PROP   = 10;
    localparam int          POS_CLK_MODE    = 11;
    localparam int          POS_BUS_MODE    = 12;
    localparam int          POS_DATA_LO     = 13;
    localparam int          POS_LPBK        = 15;
    localparam int          LPBK_LAT_CYCLES = 2;

    typedef enum logic [1:0] {
        TPC_MODE_OFF,
        TPC_MODE_UNSTRUCT,
        TPC_MODE_STRUCT,
        TPC_MODE_STRUCT_WIDE
    } tpc_data_mode_t;

    // decoded view of the upper half handed to the link side
    typedef struct packed {
        logic           fast_serial_loopback_en;
        tpc_data_mode_t data_mode;
        logic           bus_mode_framed;
        logic           clk_mode_backplane;
        logic           internal_loss_propagate_en;
        logic           link_is_ds1;
        logic           clk_rate_high;
        logic           input_sample_edge_sel;
    } tpc_cfg_t;

    // register-side controls that come from neighbouring registers
    typedef struct packed {
        logic egress_port_active;
        logic output_drive_edge_sel;
        logic loss_clock_switchover_en;
    } tpc_ext_t;
endpackage

/* rtl/tpc_port_config.sv */
// tpc_port_config: per-port tdm ingress config register (upper half) plus its serial path
// assumes: microprocessor port is a simple 16-bit word strobe bus on ref_clk_in;
// neighbouring register bits arrive as plain inputs; port clock is unrelated to ref_clk_in
//
// Function
// - input data sampled rising edge when edge select 0, falling when 1
// - rate bit picks 1.544 or 2.048/4.096 MHz; link bit picks E1 or DS1
// - unstructured with loss propagate set forwards port loss internally
// - clocking bit picks own clock and pulse or common backplane ones; ignored in unstructured mode, which keeps own clock
// - bus bit picks generic or framed backplane format at 4.096 MHz; ignored in unstructured mode, which keeps generic
// - data mode: off, unstructured, structured, structured wide
// - fast loopback routes serial input straight to serial output
// - loopback drives output even when egress port inactive
// - loopback latency about two port clock cycles
// - register at base 6200 plus 10 hex per port, resets to zero
// - switchover in unstructured mode selects internal clock on loss
// - output driven falling edge when drive select 0, rising when 1
// - inactive egress port holds output high impedance except in loopback
`timescale 1ns/1ps
module tpc_port_config #(
    parameter logic [4:0] PORT_NUM = 5'h00
) (
    input  wire logic        ref_clk_in,
    input  wire logic        srst_in,
    input  wire logic        clk_en_in,
    input  wire logic [15:0] cpu_addr_in,
    input  wire logic        cpu_wr_in,
    input  wire logic        cpu_rd_in,
    input  wire logic [15:0] cpu_wdata_in,
    input  wire logic        egress_port_active_in,
    input  wire logic        output_drive_edge_sel_in,
    input  wire logic        loss_clock_switchover_en_in,
    input  wire logic        signalling_or_loss_in,
    input  wire logic        port_clk_in,
    input  wire logic        serial_data_in,
    input  wire logic        reass_data_in,
    output logic      [15:0] cpu_rdata_out,
    output logic             cpu_rvalid_out,
    output logic             clk_rate_high_out,
    output logic             link_is_ds1_out,
    output logic             use_backplane_clock_out,
    output logic             framed_format_out,
    output logic             cells_enabled_out,
    output logic             structured_wide_out,
    output logic             internal_loss_event_out,
    output logic             internal_clock_sel_out,
    output logic             serial_data_out,
    output logic             serial_data_oe_n_out,
    output logic             rx_bit_out
);
    localparam logic [15:0] MY_ADDR = 16'(tpc_pkg::REG_BASE + tpc_pkg::PORT_STRIDE * 16'(PORT_NUM));

    logic [15:0]       cfg;
    logic [15:0]       next_cfg;
    logic [15:0]       next_rdata;
    logic              next_rvalid;
    logic [2:0]        los_sync;
    logic              los_level;
    logic              next_los_level;
    tpc_pkg::tpc_cfg_t cfg_view;
    tpc_pkg::tpc_ext_t ext_view;
    tpc_pkg::tpc_cfg_t cfg_l1;
    tpc_pkg::tpc_cfg_t cfg_l2;
    tpc_pkg::tpc_ext_t ext_l1;
    tpc_pkg::tpc_ext_t ext_l2;
    logic [1:0]        prst_sync;
    logic              rst_req;
    logic              next_rst_req;
    logic [1:0]        rst_ack_sync;
    logic [6:0]        o_next;
    logic              unstruct;

    // register write and read decode
    always_comb
    begin
        next_cfg    = cfg;
        next_rdata  = cpu_rdata_out;
        next_rvalid = 1'b0;
        if (cpu_wr_in && cpu_addr_in == MY_ADDR)
            next_cfg = cpu_wdata_in & ~tpc_pkg::LOWER_MASK;
        else if (cpu_rd_in && cpu_addr_in == MY_ADDR)
        begin
            next_rdata  = cfg;
            next_rvalid = 1'b1;
        end
        else if (cpu_rd_in)
        begin
            next_rdata  = 16'h0000; // unmapped reads as zero
            next_rvalid = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            cfg            <= tpc_pkg::CFG_RESET;
            cpu_rdata_out  <= 16'h0000;
            cpu_rvalid_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            cfg            <= next_cfg;
            cpu_rdata_out  <= next_rdata;
            cpu_rvalid_out <= next_rvalid;
        end
    end

    // field view of the stored word
    always_comb
    begin
        cfg_view.input_sample_edge_sel      = cfg[tpc_pkg::POS_SAMPLE_EDGE];
        cfg_view.clk_rate_high              = cfg[tpc_pkg::POS_CLK_RATE];
        cfg_view.link_is_ds1                = cfg[tpc_pkg::POS_LINK_TYPE];
        cfg_view.internal_loss_propagate_en = cfg[tpc_pkg::POS_LOSS_PROP];
        cfg_view.clk_mode_backplane         = cfg[tpc_pkg::POS_CLK_MODE];
        cfg_view.bus_mode_framed            = cfg[tpc_pkg::POS_BUS_MODE];
        cfg_view.data_mode                  = tpc_pkg::tpc_data_mode_t'(cfg[tpc_pkg::POS_DATA_LO +: 2]);
        cfg_view.fast_serial_loopback_en    = cfg[tpc_pkg::POS_LPBK];
        ext_view.egress_port_active         = egress_port_active_in;
        ext_view.output_drive_edge_sel      = output_drive_edge_sel_in;
        ext_view.loss_clock_switchover_en   = loss_clock_switchover_en_in;
        unstruct = (cfg_view.data_mode == tpc_pkg::TPC_MODE_UNSTRUCT);
    end

    // loss pin is asynchronous: three stages, act when last two agree
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
            los_sync <= 3'h0;
        else if (clk_en_in)
            los_sync <= {los_sync[1:0], signalling_or_loss_in};
    end

    always_comb
    begin
        next_los_level = (los_sync[2] == los_sync[1]) ? los_sync[2] : los_level;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
            los_level <= 1'b0;
        else if (clk_en_in)
            los_level <= next_los_level;
    end

    // decoded controls; structured-only bits are ignored in unstructured mode
    always_comb
    begin
        o_next[0] = cfg_view.clk_rate_high;
        o_next[1] = cfg_view.link_is_ds1;
        o_next[2] = cfg_view.clk_mode_backplane && !unstruct;
        o_next[3] = cfg_view.bus_mode_framed && !unstruct;
        o_next[4] = (cfg_view.data_mode != tpc_pkg::TPC_MODE_OFF);
        o_next[5] = (cfg_view.data_mode == tpc_pkg::TPC_MODE_STRUCT_WIDE);
        o_next[6] = unstruct && cfg_view.internal_loss_propagate_en && los_level;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            {internal_loss_event_out, structured_wide_out, cells_enabled_out, framed_format_out,
             use_backplane_clock_out, link_is_ds1_out, clk_rate_high_out} <= 7'h00;
            internal_clock_sel_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            {internal_loss_event_out, structured_wide_out, cells_enabled_out, framed_format_out,
             use_backplane_clock_out, link_is_ds1_out, clk_rate_high_out} <= o_next;
            internal_clock_sel_out <= unstruct && ext_view.loss_clock_switchover_en && los_level;
        end
    end

    // reset request held until the port domain echoes it, so a short srst_in still reaches a slow port clock
    always_comb
    begin
        if (rst_ack_sync[1])
            next_rst_req = 1'b0;
        else
            next_rst_req = rst_req;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            rst_req      <= 1'b1;
            rst_ack_sync <= 2'b00;
        end
        else if (clk_en_in)
        begin
            rst_req      <= next_rst_req;
            rst_ack_sync <= {rst_ack_sync[0], prst_sync[1]};
        end
    end

    // quasi-static config into the port domain; two stages is enough for settled levels
    always_ff @(posedge port_clk_in)
    begin
        cfg_l1    <= cfg_view;
        cfg_l2    <= cfg_l1;
        ext_l1    <= ext_view;
        ext_l2    <= ext_l1;
        prst_sync <= {prst_sync[0], rst_req};
    end

    tpc_serial_path u_path (
        .port_clk_in          (port_clk_in),
        .port_rst_in          (prst_sync[1]),
        .cfg_in               (cfg_l2),
        .ext_in               (ext_l2),
        .serial_data_in       (serial_data_in),
        .reass_data_in        (reass_data_in),
        .serial_data_out      (serial_data_out),
        .serial_data_oe_n_out (serial_data_oe_n_out),
        .rx_bit_out           (rx_bit_out)
    );

    chk_reset_zero : assert property (@(posedge ref_clk_in)
        srst_in |=> (cfg == 16'h0000))
        else $error("register not zero after reset");
    chk_write_readback : assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (clk_en_in && cpu_wr_in && cpu_addr_in == MY_ADDR) ##1 (clk_en_in && cpu_rd_in && cpu_addr_in == MY_ADDR)
        |=> (cpu_rdata_out == ($past(cpu_wdata_in, 2) & ~tpc_pkg::LOWER_MASK)))
        else $error("readback differs from write");
    chk_wide_mode : assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (clk_en_in && cfg[14:13] == 2'h3) |=> (structured_wide_out && cells_enabled_out))
        else $error("wide mode not decoded");
    chk_loss_gate : assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (clk_en_in && !cfg[tpc_pkg::POS_LOSS_PROP]) |=> !internal_loss_event_out)
        else $error("loss forwarded while disabled");
    chk_struct_bits : assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (clk_en_in && unstruct) |=> (!use_backplane_clock_out && !framed_format_out))
        else $error("structured bits active in unstructured mode");
endmodule

/* rtl/tpc_serial_path.sv */
// tpc_serial_path: serial data path on the port clock, sampling edge select and fast loopback
// assumes: cfg/ext already resynchronised into this domain; link clock may stop between frames
`timescale 1ns/1ps
module tpc_serial_path (
    input  wire logic             port_clk_in,
    input  wire logic             port_rst_in,
    input  wire tpc_pkg::tpc_cfg_t cfg_in,
    input  wire tpc_pkg::tpc_ext_t ext_in,
    input  wire logic             serial_data_in,
    input  wire logic             reass_data_in,
    output logic                  serial_data_out,
    output logic                  serial_data_oe_n_out,
    output logic                  rx_bit_out
);
    logic rise_smp;
    logic fall_smp;
    logic rx_bit;
    logic next_rx_bit;
    logic out_rise;
    logic out_fall;
    logic next_out;
    logic next_oe_n;

    // capture on both edges, choose afterwards
    always_ff @(posedge port_clk_in)
    begin
        rise_smp <= serial_data_in;
    end

    always_ff @(negedge port_clk_in)
    begin
        fall_smp <= serial_data_in;
    end

    // selected input bit, one cycle of retiming
    always_comb
    begin
        next_rx_bit = cfg_in.input_sample_edge_sel ? fall_smp : rise_smp;
    end

    always_ff @(posedge port_clk_in)
    begin
        if (port_rst_in)
            rx_bit <= 1'b0;
        else
            rx_bit <= next_rx_bit;
    end

    // loopback bypasses the reassembly data entirely; about two port clocks end to end
    always_comb
    begin
        next_out  = cfg_in.fast_serial_loopback_en ? rx_bit : reass_data_in;
        next_oe_n = !(ext_in.egress_port_active || cfg_in.fast_serial_loopback_en);
    end

    always_ff @(posedge port_clk_in)
    begin
        if (port_rst_in)
            out_rise <= 1'b0;
        else
            out_rise <= next_out;
    end

    always_ff @(negedge port_clk_in)
    begin
        if (port_rst_in)
            out_fall <= 1'b0;
        else
            out_fall <= next_out;
    end

    always_ff @(posedge port_clk_in)
    begin
        if (port_rst_in)
            serial_data_oe_n_out <= 1'b1;
        else
            serial_data_oe_n_out <= next_oe_n;
    end

    // drive edge: 0 falling, 1 rising
    always_comb
    begin
        serial_data_out = ext_in.output_drive_edge_sel ? out_rise : out_fall;
    end

    assign rx_bit_out = rx_bit;

    chk_oe_follows_ctrl : assert property (@(posedge port_clk_in) disable iff (port_rst_in)
        (!ext_in.egress_port_active && !cfg_in.fast_serial_loopback_en) |=> serial_data_oe_n_out)
        else $error("output enabled while port inactive");
    chk_loop_drives_out : assert property (@(posedge port_clk_in) disable iff (port_rst_in)
        cfg_in.fast_serial_loopback_en |=> !serial_data_oe_n_out)
        else $error("loopback not driving output");
    chk_loop_data_path : assert property (@(posedge port_clk_in) disable iff (port_rst_in)
        (cfg_in.fast_serial_loopback_en && !ext_in.output_drive_edge_sel) |-> (serial_data_out == rx_bit))
        else $error("loopback data mismatch");
endmodule

/* test/tpc_framer_model.sv */
// tpc_framer_model: line-side framer stand-in, makes the port clock and the serial stream
// assumes: run_in high while frames flow; clock parks low when idle, and data is inverted once as run_in falls and once more if the clock then parks from high
`timescale 1ns/1ps
module tpc_framer_model (
    input  wire logic run_in,
    output logic      port_clk_out,
    output logic      serial_data_out
);
    logic [6:0] lfsr = 7'h5a;

    // 125 ns period, offset so it never lines up with the system clock
    initial
    begin
        port_clk_out = 1'b0;
        #3.1;
        forever
        begin
            #62.5;
            port_clk_out = run_in ? ~port_clk_out : 1'b0; // clock stands still outside frames
        end
    end

    // launch on falling edge so a rising-edge sampler sees a settled bit;
    // a released line must not keep showing the last bit
    always @(negedge port_clk_out or negedge run_in)
    begin
        if (run_in)
        begin
            lfsr            <= {lfsr[5:0], lfsr[6] ^ lfsr[5]};
            serial_data_out <= lfsr[6];
        end
        else
            serial_data_out <= ~serial_data_out;
    end
endmodule

/* test/tpc_port_config_tb_top.sv */
// tpc_port_config_tb_top: register access, mode decode, loss and fast loopback tests
// assumes: port 0 instance, framer model drives port clock and serial input
`timescale 1ns/1ps
module tpc_port_config_tb_top;
    logic        ref_clk_in, srst_in, clk_en_in, cpu_wr_in, cpu_rd_in, run;
    logic [15:0] cpu_addr_in, cpu_wdata_in, cpu_rdata_out;
    logic        egress_in, drive_sel_in, switch_in, loss_in, port_clk, sdi, sdo, oe_n, rx_bit;
    logic        rvalid, rate, ds1, bplane, framed, cells, wide, loss_evt, int_clk;
    logic [2:0]  hist;
    int          num_errors, cmp_count, cycles;

    tpc_framer_model u_tpc_framer_model (.run_in(run), .port_clk_out(port_clk), .serial_data_out(sdi));

    tpc_port_config u_tpc_port_config (
        .ref_clk_in(ref_clk_in), .srst_in(srst_in), .clk_en_in(clk_en_in), .cpu_addr_in(cpu_addr_in),
        .cpu_wr_in(cpu_wr_in), .cpu_rd_in(cpu_rd_in), .cpu_wdata_in(cpu_wdata_in),
        .egress_port_active_in(egress_in), .output_drive_edge_sel_in(drive_sel_in),
        .loss_clock_switchover_en_in(switch_in), .signalling_or_loss_in(loss_in), .port_clk_in(port_clk),
        .serial_data_in(sdi), .reass_data_in(sdi), .cpu_rdata_out(cpu_rdata_out), .cpu_rvalid_out(rvalid),
        .clk_rate_high_out(rate), .link_is_ds1_out(ds1), .use_backplane_clock_out(bplane),
        .framed_format_out(framed), .cells_enabled_out(cells), .structured_wide_out(wide),
        .internal_loss_event_out(loss_evt), .internal_clock_sel_out(int_clk), .serial_data_out(sdo),
        .serial_data_oe_n_out(oe_n), .rx_bit_out(rx_bit));

    initial
    begin
        ref_clk_in = 1'b0;
        forever #2 ref_clk_in = ~ref_clk_in;
    end

    // history of the input as the rising-edge sampler sees it
    always @(posedge port_clk)
        hist <= {hist[1:0], sdi};

    // hang guard
    always @(posedge ref_clk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            close_out();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk_in);
        cpu_addr_in  <= a;
        cpu_wdata_in <= d;
        cpu_wr_in    <= 1'b1;
        @(posedge ref_clk_in);
        cpu_wr_in    <= 1'b0;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        int n;
        @(posedge ref_clk_in);
        cpu_addr_in <= a;
        cpu_rd_in   <= 1'b1;
        @(posedge ref_clk_in);
        cpu_rd_in   <= 1'b0;
        n = 0;
        @(posedge ref_clk_in);
        while (rvalid !== 1'b1 && n < 4)
        begin
            @(posedge ref_clk_in);
            n++;
        end
        chk({15'h0000, rvalid}, 16'h0001);
        chk(cpu_rdata_out, exp);
    endtask

    // write, then read the same word on the very next cycle
    task automatic wr_rd_chk(input logic [15:0] a, input logic [15:0] d, input logic [15:0] exp);
        @(posedge ref_clk_in);
        cpu_addr_in  <= a;
        cpu_wdata_in <= d;
        cpu_wr_in    <= 1'b1;
        @(posedge ref_clk_in);
        cpu_wr_in    <= 1'b0;
        cpu_rd_in    <= 1'b1;
        @(posedge ref_clk_in);
        cpu_rd_in    <= 1'b0;
        @(posedge ref_clk_in);
        chk({15'h0000, rvalid}, 16'h0001);
        chk(cpu_rdata_out, exp);
    endtask

    // wait port clocks, then realign to a system clock edge for the next stimulus
    task automatic pwait(input int n);
        repeat (n) @(posedge port_clk);
        @(posedge ref_clk_in);
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    logic [15:0] vals [3] = '{16'hffff, 16'h0280, 16'h4100};
    logic [15:0] v;

    // main sequence; reset held 12 system clocks, less than one port clock period
    initial
    begin
        {srst_in, clk_en_in, run} = 3'b111;
        {cpu_wr_in, cpu_rd_in, egress_in, drive_sel_in, switch_in, loss_in} = 6'h00;
        cpu_addr_in  = 16'h0000;
        cpu_wdata_in = 16'h0000;
        repeat (12) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        rd_chk(16'h6200, 16'h0000);
        rd_chk(16'h6210, 16'h0000);
        pwait(8);
        chk({15'h0000, oe_n}, 16'h0001);
        $display("reset and map test done");
        foreach (vals[i])
        begin
            wr(16'h6200, vals[i]);
            rd_chk(16'h6200, vals[i] & 16'hff80);
            chk({14'h0000, rate, ds1}, {14'h0000, vals[i][8], vals[i][9]});
        end
        clk_en_in <= 1'b0;
        wr(16'h6200, 16'h0000);
        clk_en_in <= 1'b1;
        rd_chk(16'h6200, 16'h4100);
        wr_rd_chk(16'h6200, 16'h5a5a, 16'h5a00);
        $display("readback test done");
        for (int m = 0; m < 4; m++)
        begin
            v = {1'b0, m[1:0], 13'h0000} | ((m != 1) ? 16'h1880 : 16'h0000);
            wr(16'h6200, v);
            repeat (3) @(posedge ref_clk_in);
            chk({12'h000, bplane, framed, cells, wide}, {12'h000, m != 1, m != 1, m != 0, m == 3});
        end
        $display("data mode test done");
        switch_in <= 1'b1;
        wr(16'h6200, 16'h2400);
        loss_in <= 1'b1;
        repeat (20) @(posedge ref_clk_in);
        chk({14'h0000, loss_evt, int_clk}, 16'h0003);
        switch_in <= 1'b0;
        repeat (20) @(posedge ref_clk_in);
        chk({14'h0000, loss_evt, int_clk}, 16'h0002);
        loss_in <= 1'b0;
        repeat (20) @(posedge ref_clk_in);
        chk({14'h0000, loss_evt, int_clk}, 16'h0000);
        switch_in <= 1'b0;
        wr(16'h6200, 16'h4400);
        loss_in <= 1'b1;
        repeat (20) @(posedge ref_clk_in);
        chk({14'h0000, loss_evt, int_clk}, 16'h0000);
        loss_in <= 1'b0;
        $display("loss test done");
        wr(16'h6200, 16'h8000);
        pwait(10);
        repeat (16)
        begin
            @(negedge port_clk);
            chk({13'h0000, oe_n, rx_bit, sdo}, {14'h0000, hist[1], hist[2]});
        end
        wr(16'h6200, 16'h0000);
        pwait(10);
        chk({15'h0000, oe_n}, 16'h0001);
        egress_in <= 1'b1;
        pwait(10);
        chk({15'h0000, oe_n}, 16'h0000);
        repeat (8)
        begin
            @(negedge port_clk);
            chk({15'h0000, sdo}, {15'h0000, hist[1]});
        end
        @(posedge ref_clk_in);
        drive_sel_in <= 1'b1;
        pwait(10);
        repeat (8)
        begin
            @(negedge port_clk);
            chk({15'h0000, sdo}, {15'h0000, hist[0]});
        end
        $display("loopback test done");
        close_out();
    end
endmodule
